// ### src/clcrs_pkg.sv
// shared constants, state encoding and decode helpers of the classifier rule store
package clcrs_pkg;

	// ************************************************************
	// geometry
	// ************************************************************
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned ENTRY_W = 36;
	localparam int unsigned ACTION_W = 70;
	localparam int unsigned MAX_SPAN = 16;
	localparam int unsigned MAX_ASPAN = 4;
	localparam int unsigned KEY_W = 576;
	localparam int unsigned RES_W = 280;
	localparam int unsigned POOL_BLOCKS = 6;
	localparam int unsigned BLOCK_LG = 10;
	localparam int unsigned MEM_DEPTH = 7584;
	localparam logic [12:0] POOL_DEPTH = 13'h1800;

	// ************************************************************
	// default rules
	// ************************************************************
	localparam logic [4:0] DFLT_RULES = 5'h1e;
	localparam logic [12:0] DFLT_BASE_A = 13'h1800;
	localparam logic [12:0] DFLT_BASE_B = 13'h19e0;
	localparam logic [12:0] DFLT_BASE_C = 13'h1bc0;
	localparam logic [1:0] INST_A = 2'h0;
	localparam logic [1:0] INST_B = 2'h1;
	localparam logic [1:0] INST_C = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RD = 3'b001,
		S_EV = 3'b010,
		S_ARD = 3'b011,
		S_AEV = 3'b100,
		S_DONE = 3'b101
	} clcrs_state_t;

	// lowest set bit of a size code: {found, position}
	function automatic logic [3:0] lowest_one(input logic [4:0] v);
		logic [3:0] r;
		r = 4'h0;
		if (v[0]) begin
			r = 4'h8;
		end else if (v[1]) begin
			r = 4'h9;
		end else if (v[2]) begin
			r = 4'ha;
		end else if (v[3]) begin
			r = 4'hb;
		end else if (v[4]) begin
			r = 4'hc;
		end
		return r;
	endfunction

	// width of the low type-group field at an address offset
	function automatic logic [2:0] tg_width(input logic [3:0] off, input logic [2:0] lg);
		logic [2:0] w;
		w = 3'h4;
		if (off == 4'h0) begin
			w = lg + 3'h1;
		end else if (off[0]) begin
			w = 3'h1;
		end else if (off[1]) begin
			w = 3'h2;
		end else if (off[2]) begin
			w = 3'h3;
		end
		return w;
	endfunction

endpackage

// ### src/clcrs_word_match.sv
// one stored address word against one key word with the type-group inserted
module clcrs_word_match (
	input wire logic [3:0] off_i,
	input wire logic [2:0] size_lg_i,
	input wire logic [35:0] key_word_i,
	input wire logic [35:0] ent_i,
	input wire logic [35:0] msk_i,
	output logic hit_o
);

	logic [2:0] width;
	logic [4:0] code;
	logic [35:0] expect_word;

	always_comb begin
		width = clcrs_pkg::tg_width(off_i, size_lg_i);
		code = (off_i == 4'h0) ? (5'h01 << size_lg_i) : 5'h00;
		expect_word = key_word_i;
		for (int i = 0; i < 5; i++) begin
			if (3'(i) < width) begin
				expect_word[i] = code[i];
			end
		end
		// mask bit high means don't care
		hit_o = &((~(expect_word ^ ent_i)) | msk_i);
	end

endmodule

// ### src/clcrs_dflt_addr.sv
// start address of the selected default rule of one lookup instance
module clcrs_dflt_addr (
	input wire logic [1:0] inst_i,
	input wire logic [4:0] idx_i,
	output logic [12:0] addr_o
);

	logic [4:0] idx;
	logic [12:0] base;

	always_comb begin
		// an index past the last rule falls back to the last rule
		idx = (idx_i < clcrs_pkg::DFLT_RULES) ? idx_i : (clcrs_pkg::DFLT_RULES - 5'h1);
		case (inst_i)
			clcrs_pkg::INST_B: base = clcrs_pkg::DFLT_BASE_B;
			clcrs_pkg::INST_C: base = clcrs_pkg::DFLT_BASE_C;
			default: base = clcrs_pkg::DFLT_BASE_A;
		endcase
		addr_o = base + {4'h0, idx, 4'h0};
	end

endmodule

// ### src/clcrs_store.sv
// first-stage classifier rule store: memory, span matching, defaults and hit counters
// Functional notes
// - storage comes from the shared block pool
// - each allocated block adds 1024 addresses
// - per-address hit counter, one bit, saturating
// - entries span 1 to 16 addresses
// - actions span 1, 2 or 4 addresses
// - payload fills above the type-group bits
// - default rule chosen alongside each lookup
// - instance a defaults at 6144 plus 16n
// - instance b defaults at 6624 plus 16n
// - instance c defaults at 7104 plus 16n
// - only offset-0 counter counts a hit
module clcrs_store (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] alloc_i,
	input wire logic wr_en_i,
	input wire logic [12:0] wr_addr_i,
	input wire logic [35:0] wr_entry_i,
	input wire logic [35:0] wr_mask_i,
	input wire logic [69:0] wr_action_i,
	input wire logic wr_cnt_i,
	input wire logic rd_en_i,
	input wire logic [12:0] rd_addr_i,
	input wire logic key_valid_i,
	input wire logic [575:0] key_i,
	input wire logic [1:0] key_inst_i,
	input wire logic [4:0] key_dflt_i,
	output logic ready_o,
	output logic rd_valid_o,
	output logic [35:0] rd_entry_o,
	output logic [35:0] rd_mask_o,
	output logic [69:0] rd_action_o,
	output logic rd_cnt_o,
	output logic res_valid_o,
	output logic res_default_o,
	output logic [12:0] res_addr_o,
	output logic [2:0] res_act_size_o,
	output logic [279:0] res_action_o
);

	// ************************************************************
	// storage
	// ************************************************************
	logic [35:0] ent_mem [clcrs_pkg::MEM_DEPTH];
	logic [35:0] msk_mem [clcrs_pkg::MEM_DEPTH];
	logic [69:0] act_mem [clcrs_pkg::MEM_DEPTH];
	logic cnt_mem [clcrs_pkg::MEM_DEPTH];

	clcrs_pkg::clcrs_state_t state;
	clcrs_pkg::clcrs_state_t next_state;
	logic [12:0] start;
	logic [12:0] next_start;
	logic [3:0] off;
	logic [3:0] next_off;
	logic [2:0] size_lg;
	logic [2:0] next_size_lg;
	logic [1:0] act_lg;
	logic [1:0] next_act_lg;
	logic is_dflt;
	logic next_is_dflt;
	logic [575:0] key_q;
	logic [1:0] inst_q;
	logic [4:0] dflt_q;
	logic rd_pend;
	logic [35:0] q_ent;
	logic [35:0] q_msk;
	logic [69:0] q_act;
	logic q_cnt;
	logic [12:0] cur_addr;
	logic [12:0] mem_addr;
	logic [12:0] dflt_addr;
	logic [3:0] ent_code;
	logic [3:0] act_code;
	logic [2:0] cmp_lg;
	logic word_hit;
	logic [4:0] span;
	logic [3:0] align_mask;
	logic idle;

	assign idle = (state == clcrs_pkg::S_IDLE);
	assign cur_addr = start + {9'h0, off};
	// software read port owns the memory while idle
	assign mem_addr = idle ? rd_addr_i : cur_addr;

	// ************************************************************
	// memory ports
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (wr_en_i && idle && (wr_addr_i < 13'(clcrs_pkg::MEM_DEPTH))) begin
			ent_mem[wr_addr_i] <= wr_entry_i;
			msk_mem[wr_addr_i] <= wr_mask_i;
			act_mem[wr_addr_i] <= wr_action_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_en_i && idle && (wr_addr_i < 13'(clcrs_pkg::MEM_DEPTH))) begin
			cnt_mem[wr_addr_i] <= wr_cnt_i;
		end else if (state == clcrs_pkg::S_DONE) begin
			cnt_mem[start] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (mem_addr < 13'(clcrs_pkg::MEM_DEPTH)) begin
			q_ent <= ent_mem[mem_addr];
			q_msk <= msk_mem[mem_addr];
			q_act <= act_mem[mem_addr];
			q_cnt <= cnt_mem[mem_addr];
		end else begin
			q_ent <= 36'h0;
			q_msk <= 36'h0;
			q_act <= 70'h0;
			q_cnt <= 1'b0;
		end
	end

	// ************************************************************
	// matching helpers
	// ************************************************************
	// decode stored size code
	assign ent_code = clcrs_pkg::lowest_one(q_ent[4:0]);
	assign act_code = clcrs_pkg::lowest_one({2'h0, q_act[2:0]});
	assign cmp_lg = (off == 4'h0) ? ent_code[2:0] : size_lg;
	assign span = 5'h01 << cmp_lg;
	assign align_mask = 4'(span - 5'h01);

	clcrs_word_match u_match (
		.off_i(off),
		.size_lg_i(cmp_lg),
		.key_word_i(key_q[off * 36 +: 36]),
		.ent_i(q_ent),
		.msk_i(q_msk),
		.hit_o(word_hit)
	);

	clcrs_dflt_addr u_dflt (
		.inst_i(inst_q),
		.idx_i(dflt_q),
		.addr_o(dflt_addr)
	);

	// ************************************************************
	// lookup sequence
	// ************************************************************
	always_comb begin
		next_state = state;
		next_start = start;
		next_off = off;
		next_size_lg = size_lg;
		next_act_lg = act_lg;
		next_is_dflt = is_dflt;
		case (state)
			clcrs_pkg::S_IDLE: begin
				if (key_valid_i) begin
					next_state = clcrs_pkg::S_RD;
					next_start = 13'h0;
					next_off = 4'h0;
					next_is_dflt = 1'b0;
				end
			end
			clcrs_pkg::S_RD: begin
				if (start >= clcrs_pkg::POOL_DEPTH) begin
					next_start = dflt_addr;
					next_off = 4'h0;
					next_is_dflt = 1'b1;
					next_state = clcrs_pkg::S_ARD;
				end else if (!alloc_i[start[12:10]]) begin
					next_start = {start[12:10] + 3'h1, 10'h0};
				end else begin
					next_state = clcrs_pkg::S_EV;
				end
			end
			clcrs_pkg::S_EV: begin
				next_state = clcrs_pkg::S_RD;
				next_off = 4'h0;
				if (off == 4'h0) begin
					if (!ent_code[3] || ((start[3:0] & align_mask) != 4'h0)) begin
						next_start = start + 13'h1;
					end else if (!word_hit) begin
						next_start = start + {8'h0, span};
					end else if (ent_code[2:0] == 3'h0) begin
						next_state = clcrs_pkg::S_ARD;
					end else begin
						next_size_lg = ent_code[2:0];
						next_off = 4'h1;
					end
				end else if (!word_hit) begin
					next_start = start + {8'h0, span};
				end else if (off == align_mask) begin
					next_state = clcrs_pkg::S_ARD;
				end else begin
					next_off = off + 4'h1;
				end
			end
			clcrs_pkg::S_ARD: begin
				next_state = clcrs_pkg::S_AEV;
			end
			clcrs_pkg::S_AEV: begin
				// action span from its own code
				if (off == 4'h0) begin
					next_act_lg = act_code[3] ? act_code[1:0] : 2'h0;
				end
				if (off[1:0] == 2'((3'h1 << next_act_lg) - 3'h1)) begin
					next_state = clcrs_pkg::S_DONE;
					next_off = 4'h0;
				end else begin
					next_state = clcrs_pkg::S_ARD;
					next_off = off + 4'h1;
				end
			end
			clcrs_pkg::S_DONE: begin
				next_state = clcrs_pkg::S_IDLE;
			end
			default: begin
				next_state = clcrs_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= clcrs_pkg::S_IDLE;
			start <= 13'h0;
			off <= 4'h0;
			size_lg <= 3'h0;
			act_lg <= 2'h0;
			is_dflt <= 1'b0;
			ready_o <= 1'b0;
		end else begin
			state <= next_state;
			start <= next_start;
			off <= next_off;
			size_lg <= next_size_lg;
			act_lg <= next_act_lg;
			is_dflt <= next_is_dflt;
			ready_o <= (next_state == clcrs_pkg::S_IDLE);
		end
	end

	// key and default selection held for the whole lookup
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			key_q <= 576'h0;
			inst_q <= 2'h0;
			dflt_q <= 5'h0;
		end else if (idle && key_valid_i) begin
			key_q <= key_i;
			inst_q <= key_inst_i;
			dflt_q <= key_dflt_i;
		end
	end

	// ************************************************************
	// results
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			res_valid_o <= 1'b0;
			res_default_o <= 1'b0;
			res_addr_o <= 13'h0;
			res_act_size_o <= 3'h0;
			res_action_o <= 280'h0;
		end else begin
			res_valid_o <= (state == clcrs_pkg::S_DONE);
			if (idle && key_valid_i) begin
				res_action_o <= 280'h0;
			end else if (state == clcrs_pkg::S_AEV) begin
				// raw words, payload above the code
				res_action_o[off[1:0] * 70 +: 70] <= q_act;
			end
			if (state == clcrs_pkg::S_DONE) begin
				res_default_o <= is_dflt;
				res_addr_o <= start;
				res_act_size_o <= 3'(3'h1 << act_lg);
			end
		end
	end

	// software read: address taken while idle, data on the next edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_pend <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_entry_o <= 36'h0;
			rd_mask_o <= 36'h0;
			rd_action_o <= 70'h0;
			rd_cnt_o <= 1'b0;
		end else begin
			rd_pend <= rd_en_i && idle;
			rd_valid_o <= rd_pend;
			if (rd_pend) begin
				rd_entry_o <= q_ent;
				rd_mask_o <= q_msk;
				rd_action_o <= q_act;
				rd_cnt_o <= q_cnt;
			end
		end
	end

endmodule

// ### dv/clcrs_store_asserts.sv
// assertions on the rule store ports
module clcrs_store_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] alloc_i,
	input wire logic key_valid_i,
	input wire logic ready_o,
	input wire logic res_valid_o,
	input wire logic res_default_o,
	input wire logic [12:0] res_addr_o,
	input wire logic [2:0] res_act_size_o
);
	logic [15:0] busy;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ************
	// helper logic
	// ************
	// a six-block scan at two cycles a word stays under the limit below
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || ready_o) begin
			busy <= 16'h0;
		end else begin
			busy <= busy + 16'h1;
		end
	end
	sequence s_take;
		key_valid_i && ready_o;
	endsequence
	sequence s_quiet;
		!res_valid_o [*5];
	endsequence
	// ************
	// properties
	// ************
	property p_busy; busy < 16'h36b0; endproperty
	a_busy: assert property (p_busy) else $error("lookup never finished");
	property p_min_lat; s_take |=> s_quiet; endproperty
	a_min_lat: assert property (p_min_lat) else $error("result too early");
	property p_take; s_take |=> !ready_o; endproperty
	a_take: assert property (p_take) else $error("ready kept after key");
	property p_ret; res_valid_o |-> $rose(ready_o); endproperty
	a_ret: assert property (p_ret) else $error("ready not back with result");
	property p_pulse; res_valid_o |=> !res_valid_o; endproperty
	a_pulse: assert property (p_pulse) else $error("result longer than a cycle");
	property p_no_alloc; res_valid_o && alloc_i == 6'h0 |-> res_default_o; endproperty
	a_no_alloc: assert property (p_no_alloc) else $error("match without blocks");
	property p_dflt;
		res_valid_o && res_default_o |-> res_addr_o >= 13'h1800 && res_addr_o <= 13'h1d90 && res_addr_o[3:0] == 4'h0;
	endproperty
	a_dflt: assert property (p_dflt) else $error("bad default address");
	property p_hit; res_valid_o && !res_default_o |-> res_addr_o < 13'h1800; endproperty
	a_hit: assert property (p_hit) else $error("hit outside pool");
	property p_asize; res_valid_o |-> res_act_size_o inside {3'h1, 3'h2, 3'h4}; endproperty
	a_asize: assert property (p_asize) else $error("bad action span");
endmodule

// ### dv/clcrs_analyzer_model.sv
// frame analyzer model: submits keys and waits for results
module clcrs_analyzer_model (
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic res_valid_i,
	output logic key_valid_o,
	output logic [575:0] key_o,
	output logic [1:0] key_inst_o,
	output logic [4:0] key_dflt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic done;
	initial begin
		key_valid_o = 1'b0;
		key_o = '0;
		key_inst_o = 2'h0;
		key_dflt_o = 5'h0;
		done = 1'b0;
	end
	// default index travels with the key
	task automatic lookup(input logic [575:0] key, input logic [1:0] inst, input logic [4:0] idx);
		int n;
		n = 0;
		done = 1'b0;
		@(negedge clk_i);
		while (ready_i !== 1'b1 && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		key_valid_o <= 1'b1;
		key_o <= key;
		key_inst_o <= inst;
		key_dflt_o <= idx;
		@(posedge clk_i);
		key_valid_o <= 1'b0;
		// released key no longer shows its value
		key_o <= ~key;
		for (n = 0; n < 20000 && !done; n++) begin
			@(negedge clk_i);
			done = (res_valid_i === 1'b1);
		end
	endtask
endmodule

// ### dv/clcrs_store_tb_top.sv
// testbench of the classifier rule store
module clcrs_store_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] inst; logic [4:0] idx; logic [12:0] addr;} clcrs_row_t;
	logic clk_i, rst_n_i, wr_en_i, wr_cnt_i, rd_en_i, key_valid_i;
	logic ready_o, rd_valid_o, rd_cnt_o, res_valid_o, res_default_o;
	logic [5:0] alloc_i;
	logic [12:0] wr_addr_i, rd_addr_i, res_addr_o;
	logic [35:0] wr_entry_i, wr_mask_i, rd_entry_o, rd_mask_o;
	logic [69:0] wr_action_i, rd_action_o;
	logic [575:0] key_i;
	logic [1:0] key_inst_i;
	logic [4:0] key_dflt_i;
	logic [2:0] res_act_size_o;
	logic [279:0] res_action_o;
	int fails = 0;
	int compares = 0;
	clcrs_row_t rows [5] = '{'{2'h0, 5'h00, 13'h1800}, '{2'h1, 5'h05, 13'h1a30},
		'{2'h2, 5'h1d, 13'h1d90}, '{2'h3, 5'h02, 13'h1820}, '{2'h0, 5'h1f, 13'h19d0}};
	// x16 entry with an x4 action at address 16; word 15 only matches through its mask bit
	logic [35:0] x16_ent [16] = '{36'h10, 36'h0, 36'h4, 36'h0, 36'h8, 36'h0, 36'h0, 36'h0,
		36'h10, 36'h0, 36'h0, 36'h0, 36'h0, 36'h0, 36'h0, {35'h15, 1'b0}};
	logic [69:0] x4_act [4] = '{{67'h41, 3'h4}, {69'h42, 1'b0}, {68'h43, 2'h0}, {69'h44, 1'b0}};
	// low key bits set where zeros are inserted, so a wrong group width shows
	localparam logic [575:0] KEY_X16 = {35'h115, 1'b1, 216'h0, 36'h1f, 108'h0, 36'hf, 36'h1, 36'h7, 36'h1,
		36'h1f};
	clcrs_store u_clcrs_store (.clk_i, .rst_n_i, .alloc_i, .wr_en_i, .wr_addr_i, .wr_entry_i, .wr_mask_i,
		.wr_action_i, .wr_cnt_i, .rd_en_i, .rd_addr_i, .key_valid_i, .key_i, .key_inst_i, .key_dflt_i, .ready_o,
		.rd_valid_o, .rd_entry_o, .rd_mask_o, .rd_action_o, .rd_cnt_o, .res_valid_o, .res_default_o, .res_addr_o,
		.res_act_size_o, .res_action_o);
	clcrs_analyzer_model u_clcrs_analyzer_model (.clk_i, .ready_i(ready_o), .res_valid_i(res_valid_o),
		.key_valid_o(key_valid_i), .key_o(key_i), .key_inst_o(key_inst_i), .key_dflt_o(key_dflt_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic final_report();
		if (fails == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [279:0] seen, input logic [279:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [35:0] e, input logic [35:0] m, input logic [69:0] act,
		input logic c);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		wr_addr_i <= a;
		wr_entry_i <= e;
		wr_mask_i <= m;
		wr_action_i <= act;
		wr_cnt_i <= c;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask
	task automatic rd_word(input logic [12:0] a, input logic [35:0] e, input logic [35:0] m, input logic [69:0] act,
		input logic c);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		@(negedge clk_i);
		chk("rd_early", rd_valid_o, 1'b0);
		@(negedge clk_i);
		chk("rd_valid", rd_valid_o, 1'b1);
		chk("rd_entry", rd_entry_o, e);
		chk("rd_mask", rd_mask_o, m);
		chk("rd_action", rd_action_o, act);
		chk("rd_cnt", rd_cnt_o, c);
		@(negedge clk_i);
		chk("rd_pulse", rd_valid_o, 1'b0);
	endtask
	task automatic reset_seq();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		chk("ready_rst", ready_o, 1'b0);
		chk("res_default_rst", res_default_o, 1'b0);
		chk("res_addr_rst", res_addr_o, 13'h0);
		chk("res_size_rst", res_act_size_o, 3'h0);
		chk("res_action_rst", res_action_o, 280'h0);
		chk("rd_valid_rst", rd_valid_o, 1'b0);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		chk("ready_first", ready_o, 1'b0);
		@(negedge clk_i);
		chk("ready_up", ready_o, 1'b1);
	endtask
	task automatic look(input logic [575:0] k, input logic [1:0] i, input logic [4:0] x, input logic d,
		input logic [12:0] a, input logic [2:0] s);
		u_clcrs_analyzer_model.lookup(k, i, x);
		chk("done", u_clcrs_analyzer_model.done, 1'b1);
		chk("res_default", res_default_o, d);
		chk("res_addr", res_addr_o, a);
		chk("res_act_size", res_act_size_o, s);
	endtask
	initial begin
		#200us;
		fails++;
		final_report();
	end
	initial begin
		rst_n_i = 1'b0;
		alloc_i = 6'h0;
		wr_en_i = 1'b0;
		wr_addr_i = 13'h0;
		wr_entry_i = 36'h0;
		wr_mask_i = 36'h0;
		wr_action_i = 70'h0;
		wr_cnt_i = 1'b0;
		rd_en_i = 1'b0;
		rd_addr_i = 13'h0;
		reset_seq();
		// ************
		// default rows, no blocks
		// ************
		foreach (rows[r]) wr(rows[r].addr, 36'h0, 36'h0, 70'h1, 1'b0);
		foreach (rows[r]) look(576'h0, rows[r].inst, rows[r].idx, 1'b1, rows[r].addr, 3'h1);
		// ************
		// stored rules in block 0
		// ************
		for (int a = 0; a < 1024; a++) wr(13'(a), 36'h0, 36'h0, 70'h0, 1'b0);
		@(posedge clk_i);
		alloc_i <= 6'h1;
		wr(13'h0, {35'h5a5a, 1'b1}, 36'h0, {69'h33, 1'b1}, 1'b0);
		wr(13'h3, {35'h77, 1'b0}, 36'h0, {69'hbb, 1'b0}, 1'b0);
		wr(13'h2, {34'h66, 2'b10}, 36'h0, {68'haa, 2'b10}, 1'b0);
		look({540'h0, 35'h5a5a, 1'b0}, 2'h0, 5'h0, 1'b0, 13'h0, 3'h1);
		chk("action_x1", res_action_o, {210'h0, 69'h33, 1'b1});
		rd_word(13'h0, {35'h5a5a, 1'b1}, 36'h0, {69'h33, 1'b1}, 1'b1);
		rd_word(13'h1, 36'h0, 36'h0, 70'h0, 1'b0);
		// second hit must not wrap the one-bit counter
		look({540'h0, 35'h5a5a, 1'b0}, 2'h0, 5'h0, 1'b0, 13'h0, 3'h1);
		rd_word(13'h0, {35'h5a5a, 1'b1}, 36'h0, {69'h33, 1'b1}, 1'b1);
		look({504'h0, 35'h77, 1'b0, 34'h66, 2'b00}, 2'h0, 5'h0, 1'b0, 13'h2, 3'h2);
		chk("action_x2", res_action_o, {140'h0, 69'hbb, 1'b0, 68'haa, 2'b10});
		look({504'h0, 35'h78, 1'b0, 34'h66, 2'b00}, 2'h1, 5'h5, 1'b1, 13'h1a30, 3'h1);
		wr(13'h5, {34'h7, 2'b10}, 36'h0, 70'h0, 1'b0);
		for (int a = 15; a >= 0; a--) wr(13'(16 + a), x16_ent[a], (a == 15) ? {35'h100, 1'b0} : 36'h0,
			(a < 4) ? x4_act[a] : 70'h0, 1'b0);
		look(KEY_X16, 2'h2, 5'h3, 1'b0, 13'h10, 3'h4);
		chk("action_x4", res_action_o, {x4_act[3], x4_act[2], x4_act[1], x4_act[0]});
		rd_word(13'h1f, {35'h15, 1'b0}, {35'h100, 1'b0}, 70'h0, 1'b0);
		// memory and counters are not cleared by a reset in mid-run
		reset_seq();
		rd_word(13'h10, 36'h10, 36'h0, x4_act[0], 1'b1);
		final_report();
	end
endmodule
bind clcrs_store clcrs_store_asserts u_clcrs_store_asserts (.clk_i, .rst_n_i, .alloc_i, .key_valid_i, .ready_o,
	.res_valid_o, .res_default_o, .res_addr_o, .res_act_size_o);
